// ---- src/ptc_phy_regs.sv ----
`timescale 1ns/1ps
// Operation
// - Receive-error-full latches after 64 errored packets; cleared by reading status or by writing the clear register.
// - Enable bit 6 gates auto-negotiation-completed interrupt; resets to zero.
// - Enable bit 5 gates remote-fault-detected interrupt.
// - Enable bit 4 gates link-down interrupt; resets to zero.
// - Enable bit 3 gates link-code-word acknowledge interrupt.
// - Enable bit 2 gates parallel-detection-fault interrupt; resets to zero.
// - Enable bit 1 gates auto-negotiation-page-received interrupt.
// - Enable bit 0 gates receive-error-full interrupt; resets to zero.
// - Control bit 13 set stops the receive error counter; resets zero.
// - Control bit 12 reads the auto-negotiation-complete status bit.
// - Control bit 8 enables receive DC restoration; resets to one.
// - Control bit 7 enables NRZ/NRZI conversions both ways; resets to one.
// - Control bit 5 isolates the transmitter; zero for normal traffic.
// - Bits 4 to 2 report the current operating mode, read only.
// - Control bit 1 bypasses the MLT3 encoder and decoder; resets zero.
// - Control bit 0 disables scrambler and descrambler; resets zero.
module ptc_phy_regs import ptc_pkg::*; (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Transceiver events, one-cycle pulses
  input wire logic AUTONEG_DONE_EVT,
  input wire logic REMOTE_FAULT_EVT,
  input wire logic LINK_DOWN_EVT,
  input wire logic AUTONEG_ACK_EVT,
  input wire logic PARALLEL_FAULT_EVT,
  input wire logic PAGE_RX_EVT,
  input wire logic RX_ERR_PKT,
  // Transceiver state
  input wire logic AUTONEG_DONE,
  input wire logic [2:0] OPERATING_MODE,
  input wire logic [1:0] HOST_LOOPBACK_MODE,
  // Line controls
  output ptc_line_s LINE_CTRL,
  // Interrupt
  output logic IRQ
);

  logic [15:0] irq_enable;
  logic [15:0] line_ctrl;
  logic [31:0] rd_data;
  logic rd_is_status;
  logic [PTC_IRQ_W-1:0] irq_status;
  logic [7:0] err_count;
  logic err_full_pulse;
  logic [15:0] next_irq_enable;
  logic [15:0] next_line_ctrl;

  // Bus phase decode.
  wire setup_phase = PSEL && !PENABLE;
  wire access_phase = PSEL && PENABLE;
  wire hit_status = (PADDR == PTC_IRQ_STATUS_OFS);
  wire hit_enable = (PADDR == PTC_IRQ_ENABLE_OFS);
  wire hit_ctrl = (PADDR == PTC_LINE_CTRL_OFS);
  wire hit_clear = (PADDR == PTC_IRQ_CLEAR_OFS);
  wire hit_count = (PADDR == PTC_ERR_COUNT_OFS);
  wire mapped = hit_status || hit_enable || hit_ctrl || hit_clear || hit_count;
  wire do_write = access_phase && PWRITE && mapped;
  wire do_read = access_phase && !PWRITE && mapped;

  // Byte enables for the low halfword, where all registers live.
  wire [15:0] lane_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask,
                                        input logic [15:0] data, input logic [15:0] lanes);
    logic [15:0] m;
    m = wmask & lanes;
    merge = (old & ~m) | (data & m);
  endfunction

  assign next_irq_enable = (do_write && hit_enable) ?
      merge(irq_enable, 16'(2 ** PTC_IRQ_W - 1), PWDATA[15:0], lane_mask) : irq_enable;
  assign next_line_ctrl = (do_write && hit_ctrl) ?
      merge(line_ctrl, PTC_LINE_CTRL_WMASK, PWDATA[15:0], lane_mask) : line_ctrl;

  // Event collection; the counter supplies the receive-error-full source.
  wire ptc_irq_s events = '{
    autoneg_done: AUTONEG_DONE_EVT,
    remote_fault: REMOTE_FAULT_EVT,
    link_down: LINK_DOWN_EVT,
    autoneg_ack: AUTONEG_ACK_EVT,
    parallel_fault: PARALLEL_FAULT_EVT,
    page_rx: PAGE_RX_EVT,
    rx_err_full: err_full_pulse
  };

  // Reading status clears only the bits that the read actually returned,
  // so an event landing between setup and access is never lost.
  wire [PTC_IRQ_W-1:0] read_clear = (do_read && rd_is_status) ?
      rd_data[PTC_IRQ_W-1:0] : '0;
  wire [PTC_IRQ_W-1:0] write_clear = (do_write && hit_clear && PSTRB[0]) ?
      PWDATA[PTC_IRQ_W-1:0] : '0;
  wire status_read = do_read && rd_is_status;

  ptc_rx_err_counter #(
    .FULL_COUNT(PTC_RX_ERR_FULL_COUNT)
  ) u_err_counter (
    .clk(CORE_CLK),
    .rst(RST),
    .count_en(!line_ctrl[PTC_CTRL_RX_ERR_OFF_BIT]),
    .err_pkt(RX_ERR_PKT),
    .restart(status_read),
    .count(err_count),
    .full_pulse(err_full_pulse)
  );

  // Enable bits gate each source onto the request line.
  ptc_irq_status #(
    .W(PTC_IRQ_W)
  ) u_irq_status (
    .clk(CORE_CLK),
    .rst(RST),
    .set_evt(events),
    .clear_mask(read_clear | write_clear),
    .enable(irq_enable[PTC_IRQ_W-1:0]),
    .status(irq_status),
    .irq(IRQ)
  );

  // Read view of the control register with its live read-only fields.
  wire [15:0] ctrl_view = {
    line_ctrl[15:13],
    AUTONEG_DONE,
    line_ctrl[11:5],
    OPERATING_MODE,
    line_ctrl[1:0]
  };

  wire [15:0] read_mux =
      hit_status ? 16'(irq_status) :
      hit_enable ? irq_enable :
      hit_ctrl ? ctrl_view :
      hit_count ? 16'(err_count) : 16'h0000;

  // Read data is captured in the setup cycle so PRDATA comes from a flop.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rd_data <= 32'h00000000;
      rd_is_status <= 1'b0;
    end else if (setup_phase) begin
      rd_data <= {16'h0000, (PWRITE ? 16'h0000 : read_mux)};
      rd_is_status <= hit_status && !PWRITE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_enable <= PTC_IRQ_ENABLE_RESET;
      line_ctrl <= PTC_LINE_CTRL_RESET;
    end else begin
      irq_enable <= next_irq_enable;
      line_ctrl <= next_line_ctrl;
    end
  end

  assign PRDATA = rd_data;
  assign PREADY = 1'b1;
  assign PSLVERR = access_phase && !mapped;

  // Remote loop-back is held off while the host loop-back field is not 00,
  // since the two paths would otherwise fight over the receive data.
  assign LINE_CTRL.remote_loopback_en = line_ctrl[PTC_CTRL_REMOTE_LOOPBACK_BIT] &&
      (HOST_LOOPBACK_MODE == 2'h0);
  assign LINE_CTRL.dc_restore_en = line_ctrl[PTC_CTRL_DC_RESTORE_BIT];
  assign LINE_CTRL.line_code_convert_en = line_ctrl[PTC_CTRL_LINE_CODE_BIT];
  assign LINE_CTRL.transmit_isolate = line_ctrl[PTC_CTRL_TX_ISOLATE_BIT];
  assign LINE_CTRL.three_level_code_bypass = line_ctrl[PTC_CTRL_MLT3_BYPASS_BIT];
  assign LINE_CTRL.scrambler_bypass = line_ctrl[PTC_CTRL_SCRAMBLER_BYPASS_BIT];

endmodule

// ---- common/ptc_pkg.sv ----
package ptc_pkg;

  // Register byte addresses on the APB.
  localparam logic [7:0] PTC_IRQ_STATUS_OFS = 8'hD4;
  localparam logic [7:0] PTC_IRQ_ENABLE_OFS = 8'hD8;
  localparam logic [7:0] PTC_LINE_CTRL_OFS = 8'hDC;
  localparam logic [7:0] PTC_IRQ_CLEAR_OFS = 8'hE0;
  localparam logic [7:0] PTC_ERR_COUNT_OFS = 8'hE4;

  localparam int PTC_REG_W = 16;
  localparam int PTC_IRQ_W = 7;

  // Interrupt source positions, shared by status, enable and clear registers.
  localparam int PTC_IRQ_AUTONEG_DONE_BIT = 6;
  localparam int PTC_IRQ_REMOTE_FAULT_BIT = 5;
  localparam int PTC_IRQ_LINK_DOWN_BIT = 4;
  localparam int PTC_IRQ_AUTONEG_ACK_BIT = 3;
  localparam int PTC_IRQ_PARALLEL_FAULT_BIT = 2;
  localparam int PTC_IRQ_PAGE_RX_BIT = 1;
  localparam int PTC_IRQ_RX_ERR_FULL_BIT = 0;

  // Line control register field positions.
  localparam int PTC_CTRL_RX_ERR_OFF_BIT = 13;
  localparam int PTC_CTRL_AUTONEG_DONE_BIT = 12;
  localparam int PTC_CTRL_REMOTE_LOOPBACK_BIT = 9;
  localparam int PTC_CTRL_DC_RESTORE_BIT = 8;
  localparam int PTC_CTRL_LINE_CODE_BIT = 7;
  localparam int PTC_CTRL_TX_ISOLATE_BIT = 5;
  localparam int PTC_CTRL_MODE_MSB = 4;
  localparam int PTC_CTRL_MODE_LSB = 2;
  localparam int PTC_CTRL_MLT3_BYPASS_BIT = 1;
  localparam int PTC_CTRL_SCRAMBLER_BYPASS_BIT = 0;

  // Reset values and writable masks.
  localparam logic [15:0] PTC_IRQ_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] PTC_LINE_CTRL_RESET = 16'h0180;
  localparam logic [15:0] PTC_LINE_CTRL_WMASK = 16'h23A3;

  // Errored packets needed to raise the receive-error-full event.
  localparam int PTC_RX_ERR_FULL_COUNT = 64;

  // Operating mode report codes.
  localparam logic [2:0] PTC_MODE_AUTONEG = 3'h0;
  localparam logic [2:0] PTC_MODE_10_HALF = 3'h1;
  localparam logic [2:0] PTC_MODE_100_HALF = 3'h2;
  localparam logic [2:0] PTC_MODE_10_FULL = 3'h5;
  localparam logic [2:0] PTC_MODE_100_FULL = 3'h6;
  localparam logic [2:0] PTC_MODE_ISOLATED = 3'h7;

  typedef struct packed {
    logic autoneg_done;
    logic remote_fault;
    logic link_down;
    logic autoneg_ack;
    logic parallel_fault;
    logic page_rx;
    logic rx_err_full;
  } ptc_irq_s;

  typedef struct packed {
    logic remote_loopback_en;
    logic dc_restore_en;
    logic line_code_convert_en;
    logic transmit_isolate;
    logic three_level_code_bypass;
    logic scrambler_bypass;
  } ptc_line_s;

endpackage

// ---- src/ptc_rx_err_counter.sv ----
`timescale 1ns/1ps
module ptc_rx_err_counter import ptc_pkg::*; #(
  parameter int FULL_COUNT = PTC_RX_ERR_FULL_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic count_en,
  input wire logic err_pkt,
  input wire logic restart,
  output logic [7:0] count,
  output logic full_pulse
);

  localparam logic [7:0] FULL_LAST = 8'(FULL_COUNT - 1);
  localparam logic [7:0] FULL_VALUE = 8'(FULL_COUNT);

  wire counting = count_en && err_pkt && (count != FULL_VALUE);
  wire [7:0] base = restart ? 8'h00 : count;
  wire [7:0] next_count = counting ? 8'(base + 8'h01) : base;

  // A packet seen on the restart edge counts toward the new window unless the count had already saturated at full.
  assign full_pulse = counting && !restart && (count == FULL_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ---- src/ptc_irq_status.sv ----
`timescale 1ns/1ps
module ptc_irq_status import ptc_pkg::*; #(
  parameter int W = PTC_IRQ_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] set_evt,
  input wire logic [W-1:0] clear_mask,
  input wire logic [W-1:0] enable,
  output logic [W-1:0] status,
  output logic irq
);

  // Set wins over clear so an event in the clearing cycle is kept.
  wire [W-1:0] next_status = (status & ~clear_mask) | set_evt;

  assign irq = |(status & enable);

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

endmodule

// ---- verif/ptc_phy_regs_properties.sv ----
`timescale 1ns/1ps
module ptc_phy_regs_chk import ptc_pkg::*; (
  // Clock, reset and bus
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  // Transceiver side
  input wire logic AUTONEG_DONE_EVT,
  input wire logic REMOTE_FAULT_EVT,
  input wire logic LINK_DOWN_EVT,
  input wire logic AUTONEG_ACK_EVT,
  input wire logic PARALLEL_FAULT_EVT,
  input wire logic PAGE_RX_EVT,
  input wire logic RX_ERR_PKT,
  input wire logic AUTONEG_DONE,
  input wire logic [2:0] OPERATING_MODE,
  input wire ptc_line_s LINE_CTRL,
  input wire logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire acc = PSEL && PENABLE;
  wire wr_ctrl = acc && PWRITE && PADDR == PTC_LINE_CTRL_OFS && PSTRB[1:0] == 2'b11;
  wire rd_ctrl = PSEL && !PENABLE && !PWRITE && PADDR == PTC_LINE_CTRL_OFS;
  wire any_evt = AUTONEG_DONE_EVT || REMOTE_FAULT_EVT || LINK_DOWN_EVT || AUTONEG_ACK_EVT
    || PARALLEL_FAULT_EVT || PAGE_RX_EVT || RX_ERR_PKT;
  property p_done; rd_ctrl |=> PRDATA[12] == $past(AUTONEG_DONE); endproperty
  a_done: assert property (p_done) else $error("done mirror wrong");
  property p_mode; rd_ctrl ##1 acc |-> PRDATA[4:2] == $past(OPERATING_MODE); endproperty
  a_mode: assert property (p_mode) else $error("mode report wrong");
  property p_dcr; wr_ctrl |=> LINE_CTRL.dc_restore_en == $past(PWDATA[8]); endproperty
  a_dcr: assert property (p_dcr) else $error("dc restore wrong");
  property p_nrz; wr_ctrl ##1 1'b1 |-> LINE_CTRL.line_code_convert_en == $past(PWDATA[7]); endproperty
  a_nrz: assert property (p_nrz) else $error("line code wrong");
  property p_iso; wr_ctrl |=> LINE_CTRL.transmit_isolate == $past(PWDATA[5]); endproperty
  a_iso: assert property (p_iso) else $error("isolate wrong");
  property p_mlt; wr_ctrl |=> LINE_CTRL.three_level_code_bypass == $past(PWDATA[1]); endproperty
  a_mlt: assert property (p_mlt) else $error("mlt3 bypass wrong");
  property p_scr; wr_ctrl |=> LINE_CTRL.scrambler_bypass == $past(PWDATA[0]); endproperty
  a_scr: assert property (p_scr) else $error("scrambler bypass wrong");
  property p_rise; $rose(IRQ) |-> $past(any_evt || (acc && PWRITE)); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  property p_fall; $fell(IRQ) |-> $past(acc); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without access");
endmodule

bind ptc_phy_regs ptc_phy_regs_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PRDATA(PRDATA), .AUTONEG_DONE_EVT(AUTONEG_DONE_EVT), .REMOTE_FAULT_EVT(REMOTE_FAULT_EVT),
  .LINK_DOWN_EVT(LINK_DOWN_EVT), .AUTONEG_ACK_EVT(AUTONEG_ACK_EVT),
  .PARALLEL_FAULT_EVT(PARALLEL_FAULT_EVT), .PAGE_RX_EVT(PAGE_RX_EVT), .RX_ERR_PKT(RX_ERR_PKT),
  .AUTONEG_DONE(AUTONEG_DONE), .OPERATING_MODE(OPERATING_MODE), .LINE_CTRL(LINE_CTRL),
  .IRQ(IRQ));

// ---- verif/test_ptc_phy_regs.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_ptc_phy_regs import ptc_pkg::*; ;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, an_done = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rdata;
  logic [6:0] evt = 0;
  logic [2:0] mode = 0;
  logic [1:0] lb = 0;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  ptc_line_s line;
  int failures = 0, checked = 0;
  ptc_phy_regs uut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .AUTONEG_DONE_EVT(evt[6]), .REMOTE_FAULT_EVT(evt[5]),
    .LINK_DOWN_EVT(evt[4]), .AUTONEG_ACK_EVT(evt[3]), .PARALLEL_FAULT_EVT(evt[2]),
    .PAGE_RX_EVT(evt[1]), .RX_ERR_PKT(evt[0]), .AUTONEG_DONE(an_done),
    .OPERATING_MODE(mode), .HOST_LOOPBACK_MODE(lb), .LINE_CTRL(line), .IRQ(irq));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt <= 7'h00;
    @(posedge clk);
  endtask
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The longest stretch is the two error-packet windows, well under this span.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(0, PTC_IRQ_ENABLE_OFS, 0);
    `CHK("enable reset", 32'h0, rdata)
    apb(0, PTC_LINE_CTRL_OFS, 0);
    `CHK("ctrl reset", 32'h0180, rdata)
    `CHK("line reset", 6'h18, line)
    apb(1, PTC_LINE_CTRL_OFS, 32'hFFFF);
    apb(0, PTC_LINE_CTRL_OFS, 0);
    `CHK("ctrl ones", 32'h23A3, rdata)
    `CHK("line ones", 6'h3F, line)
    lb <= 2'b01;
    repeat (2) @(posedge clk);
    `CHK("loopback gated", 6'h1F, line)
    apb(1, PTC_LINE_CTRL_OFS, 0);
    `CHK("line zero", 6'h00, line)
    for (int k = 0; k < 6; k++) begin
      mode <= codes[k];
      an_done <= k[0];
      @(posedge clk);
      apb(0, PTC_LINE_CTRL_OFS, 0);
      `CHK("mode", {19'h0, k[0], 7'h0, codes[k], 2'h0}, rdata)
    end
    for (int i = 1; i < 7; i++) begin
      apb(1, PTC_IRQ_ENABLE_OFS, 0);
      pulse(i);
      `CHK("masked irq", 1'b0, irq)
      apb(0, PTC_IRQ_STATUS_OFS, 0);
      `CHK("status", 32'h1 << i, rdata)
      apb(1, PTC_IRQ_ENABLE_OFS, 32'h1 << i);
      pulse(i);
      `CHK("enabled irq", 1'b1, irq)
      apb(1, PTC_IRQ_CLEAR_OFS, 32'h1 << i);
      `CHK("cleared irq", 1'b0, irq)
      apb(0, PTC_IRQ_ENABLE_OFS, 0);
      `CHK("enable back", 32'h1 << i, rdata)
    end
    apb(1, PTC_IRQ_ENABLE_OFS, 32'h1);
    repeat (63) pulse(0);
    `CHK("below full", 1'b0, irq)
    pulse(0);
    `CHK("at full", 1'b1, irq)
    apb(0, PTC_IRQ_STATUS_OFS, 0);
    `CHK("full status", 32'h1, rdata)
    `CHK("read clears", 1'b0, irq)
    apb(1, PTC_LINE_CTRL_OFS, 32'h2000);
    repeat (70) pulse(0);
    `CHK("counter off", 1'b0, irq)
    apb(1, PTC_LINE_CTRL_OFS, 0);
    repeat (64) pulse(0);
    `CHK("counter on", 1'b1, irq)
    apb(0, PTC_ERR_COUNT_OFS, 0);
    `CHK("err count saturated", 32'h40, rdata)
    `CHK("ready", 1'b1, pready)
    apb(0, 8'hF0, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rdata)
    final_report;
  end
endmodule
